//--- core/gaps_map.svh
`ifndef GAPS_MAP_SVH
`define GAPS_MAP_SVH

// Clock period and pulse timings, in ns
`define GAPS_CLK_NS 50
`define GAPS_SYNC_NS 500
`define GAPS_GAP_NS 500
`define GAPS_DONE_NS 1000
`define GAPS_CMD_DLY_NS 64000
`define GAPS_FINAL_DLY_NS 100000
`define GAPS_EXECUTE_PULSE_NS 500
`define GAPS_UNBLANK_NS 2000
`define GAPS_FC_NS 500

// Least times round up to whole cycles
`define GAPS_CYC(ns) (((ns) + `GAPS_CLK_NS - 1) / `GAPS_CLK_NS)

// Register byte offsets
`define GAPS_CTRL_ADDR 12'h000
`define GAPS_STATUS_ADDR 12'h004
`define GAPS_POS_ADDR 12'h008

// Control register fields and reset value
`define GAPS_CTRL_FINAL_LSB 0
`define GAPS_CTRL_YFIRST_BIT 2
`define GAPS_CTRL_CR_BIT 3
`define GAPS_CTRL_LATE_BIT 4
`define GAPS_CTRL_RESET 5'h04

// Position register field positions
`define GAPS_POS_X_LSB 0
`define GAPS_POS_Y_LSB 16

// Characters
`define GAPS_CHR_CR 8'h0d
`define GAPS_CHR_FS 8'h1c
`define GAPS_CHR_GS 8'h1d
`define GAPS_CHR_RS 8'h1e
`define GAPS_CHR_US 8'h1f

`endif

//--- core/gaps_pkg.sv
package gaps_pkg;

   typedef enum logic [1:0] {
      GAPS_TEXT = 2'b00,
      GAPS_POINT = 2'b01,
      GAPS_VECTOR = 2'b10
   } gaps_mode_type;

   // Kind of register load; also the final-byte selector
   typedef enum logic [1:0] {
      GAPS_XLO = 2'b00,
      GAPS_YLO = 2'b01,
      GAPS_XHI = 2'b10,
      GAPS_YHI = 2'b11
   } gaps_load_type;

   typedef enum logic [3:0] {
      GAPS_IDLE = 4'b0000,
      GAPS_CMD = 4'b0001,
      GAPS_SYNC = 4'b0010,
      GAPS_GAP = 4'b0011,
      GAPS_WADONE = 4'b0100,
      GAPS_FDLY = 4'b0101,
      GAPS_EXECUTE_PULSE = 4'b0110,
      GAPS_UNBL = 4'b0111,
      GAPS_UDONE = 4'b1000,
      GAPS_FCOMP = 4'b1001
   } gaps_state_type;

endpackage

//--- core/gaps_sequencer.sv
`include "gaps_map.svh"
`timescale 1ns/1ps
`default_nettype none

module gaps_sequencer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic receive_strobe,
   input wire logic [7:0] rx_data,
   output logic receive_ready,
   output logic [7:0] latched_data_lines,
   output logic sync_strobe,
   output logic y_high_load,
   output logic y_low_load,
   output logic x_high_load,
   output logic x_low_load,
   output logic [9:0] x_position,
   output logic [9:0] y_position,
   output logic graph_command_seen,
   output logic word_assembly_flag,
   output logic word_assembly_partner,
   output logic word_assembly_flag_n,
   output logic word_assembly_done,
   output logic function_complete,
   output logic final_byte_delay,
   output logic execute_strobe,
   output logic execute_pulse,
   output logic display_timer_restart,
   output logic point_write_request,
   output logic beam_unblank,
   output logic unblank_done,
   output logic text_flag,
   output logic text_flag_second,
   output logic graphics_mode_flag,
   output logic dark_vector
);

   localparam logic [11:0] SYNC_CYC = 12'(`GAPS_CYC(`GAPS_SYNC_NS));
   localparam logic [11:0] GAP_CYC = 12'(`GAPS_CYC(`GAPS_GAP_NS));
   localparam logic [11:0] DONE_CYC = 12'(`GAPS_CYC(`GAPS_DONE_NS));
   localparam logic [11:0] CMD_CYC = 12'(`GAPS_CYC(`GAPS_CMD_DLY_NS));
   localparam logic [11:0] FDLY_CYC = 12'(`GAPS_CYC(`GAPS_FINAL_DLY_NS));
   localparam logic [11:0] EXECUTE_PULSE_CYC = 12'(`GAPS_CYC(`GAPS_EXECUTE_PULSE_NS));
   localparam logic [11:0] UNBL_CYC = 12'(`GAPS_CYC(`GAPS_UNBLANK_NS));
   localparam logic [11:0] FC_CYC = 12'(`GAPS_CYC(`GAPS_FC_NS));

   typedef struct packed {
      gaps_pkg::gaps_state_type state;
      gaps_pkg::gaps_mode_type mode;
      gaps_pkg::gaps_load_type kind;
      logic [11:0] count;
      logic [4:0] ctrl;
      logic ctl_char;
      logic leave_text;
      logic enter_plot;
      gaps_pkg::gaps_mode_type pend_mode;
      logic last_was_ylo;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic receive_ready;
      logic [7:0] data;
      logic sync_strobe;
      logic [3:0] loads;
      logic [9:0] x;
      logic [9:0] y;
      logic gcs;
      logic wa;
      logic wa_partner;
      logic wa_n;
      logic wa_done;
      logic fc;
      logic fdly;
      logic execute_pulse_strobe;
      logic execute_pulse_pulse;
      logic restart;
      logic write_req;
      logic unblank;
      logic unblank_done;
      logic text_flag;
      logic graphics;
      logic text2;
      logic dark;
   } gaps_state_vec_type;

   gaps_state_vec_type cur;
   gaps_state_vec_type next_cur;

   // One-hot load strobe vector {yhi, xhi, ylo, xlo}
   function automatic logic [3:0] gaps_load_hot(
      input gaps_pkg::gaps_load_type k);
      logic [3:0] h;
      h = 4'h0;
      h[k] = 1'b1;
      return h;
   endfunction

   // Which register field a byte addresses: bits 7,6 pick the kind;
   // the high tag is shared by X and Y, so it goes to X only right
   // after a Y low byte (only otherwise, when the Y-first strap is off)
   function automatic gaps_pkg::gaps_load_type gaps_classify(
      input logic [1:0] tag, input logic after_ylo, input logic yfirst);
      gaps_pkg::gaps_load_type k;
      case (tag)
         2'b11: k = gaps_pkg::GAPS_YLO;
         2'b10: k = gaps_pkg::GAPS_XLO;
         default: k = (after_ylo ^ ~yfirst) ? gaps_pkg::GAPS_XHI
                                             : gaps_pkg::GAPS_YHI;
      endcase
      return k;
   endfunction

   // Bus, receive path and timing sequencer
   always_comb begin
      logic [11:0] cnt_m1;
      logic bus_done;
      logic [1:0] fin_sel;
      next_cur = cur;
      cnt_m1 = cur.count - 12'h001;
      fin_sel = cur.ctrl[`GAPS_CTRL_FINAL_LSB +: 2];
      bus_done = psel && penable && cur.pready;

      // Zero-wait APB slave: ready rises during the access phase
      next_cur.pready = psel && !penable && !cur.pready;
      next_cur.pslverr = 1'b0;
      if (psel && !penable && !cur.pready) begin
         next_cur.prdata = 32'h0000_0000;
         case (paddr)
            `GAPS_CTRL_ADDR: next_cur.prdata[4:0] = cur.ctrl;
            `GAPS_STATUS_ADDR: next_cur.prdata = {20'h00000, cur.state,
               cur.dark, cur.receive_ready, cur.graphics, cur.text_flag,
               cur.mode, 2'b00};
            `GAPS_POS_ADDR: begin
               next_cur.prdata[`GAPS_POS_X_LSB +: 10] = cur.x;
               next_cur.prdata[`GAPS_POS_Y_LSB +: 10] = cur.y;
            end
            default: next_cur.pslverr = 1'b1;
         endcase
      end
      if (bus_done && pwrite && paddr == `GAPS_CTRL_ADDR) begin
         next_cur.ctrl = pwdata[4:0];
      end

      // Pulses default low; loads stay up 9 cycles in SYNC, the rest for one
      next_cur.loads = 4'h0;
      next_cur.execute_pulse_pulse = 1'b0;
      next_cur.restart = 1'b0;
      next_cur.write_req = 1'b0;
      next_cur.gcs = 1'b0;

      case (cur.state)
         gaps_pkg::GAPS_IDLE: begin
            if (receive_strobe && cur.receive_ready) begin
               next_cur.receive_ready = 1'b0;
               next_cur.data = rx_data;
               next_cur.ctl_char = 1'b0;
               next_cur.leave_text = 1'b0;
               next_cur.enter_plot = 1'b0;
               next_cur.count = CMD_CYC;
               next_cur.state = gaps_pkg::GAPS_CMD;
               if (cur.mode == gaps_pkg::GAPS_TEXT) begin
                  // Graph commands only count from text mode
                  if (rx_data == `GAPS_CHR_FS ||
                      rx_data == `GAPS_CHR_GS) begin
                     next_cur.gcs = 1'b1;
                     next_cur.wa = 1'b1;
                     next_cur.wa_partner = 1'b1;
                     next_cur.enter_plot = 1'b1;
                     next_cur.pend_mode = (rx_data == `GAPS_CHR_FS) ?
                        gaps_pkg::GAPS_POINT :
                        gaps_pkg::GAPS_VECTOR;
                     next_cur.dark = (rx_data == `GAPS_CHR_GS);
                  end
               end else if (rx_data[7:6] == 2'b00) begin
                  // Control char in a plot mode takes the text path
                  next_cur.ctl_char = 1'b1;
                  next_cur.wa_n = 1'b1;
                  next_cur.text_flag = 1'b1;
                  if (rx_data == `GAPS_CHR_US || (rx_data == `GAPS_CHR_CR
                      && cur.ctrl[`GAPS_CTRL_CR_BIT])) begin
                     next_cur.leave_text = 1'b1;
                  end else if (rx_data == `GAPS_CHR_GS &&
                               cur.mode == gaps_pkg::GAPS_VECTOR) begin
                     next_cur.dark = 1'b1;
                  end
               end else begin
                  // Address byte: sync strobe carries the load
                  next_cur.kind = gaps_classify(rx_data[7:6],
                     cur.last_was_ylo,
                     cur.ctrl[`GAPS_CTRL_YFIRST_BIT]);
                  next_cur.sync_strobe = 1'b1;
                  next_cur.count = SYNC_CYC;
                  next_cur.state = gaps_pkg::GAPS_SYNC;
               end
            end
         end

         gaps_pkg::GAPS_CMD: begin
            // Command delay, then function complete
            next_cur.count = cnt_m1;
            if (cur.count == 12'h001) begin
               next_cur.fc = 1'b1;
               next_cur.execute_pulse_strobe = 1'b0;
               next_cur.count = FC_CYC;
               next_cur.state = gaps_pkg::GAPS_FCOMP;
               if (!cur.ctrl[`GAPS_CTRL_LATE_BIT]) begin
                  next_cur.data = 8'h00;
               end
            end
         end

         gaps_pkg::GAPS_SYNC: begin
            // Load pulse spans the short sync strobe
            next_cur.loads = gaps_load_hot(cur.kind);
            next_cur.count = cnt_m1;
            case (cur.kind)
               gaps_pkg::GAPS_YHI: next_cur.y[9:5] = cur.data[4:0];
               gaps_pkg::GAPS_YLO: next_cur.y[4:0] = cur.data[4:0];
               gaps_pkg::GAPS_XHI: next_cur.x[9:5] = cur.data[4:0];
               default: next_cur.x[4:0] = cur.data[4:0];
            endcase
            if (cur.count == 12'h001) begin
               next_cur.loads = 4'h0;
               next_cur.last_was_ylo = (cur.kind == gaps_pkg::GAPS_YLO);
               if (cur.kind == gaps_pkg::gaps_load_type'(fin_sel)) begin
                  // Final byte: keep sync, run the long delay
                  next_cur.fdly = 1'b1;
                  next_cur.count = FDLY_CYC - SYNC_CYC;
                  next_cur.state = gaps_pkg::GAPS_FDLY;
                  if (cur.ctrl[`GAPS_CTRL_LATE_BIT]) begin
                     next_cur.data = 8'h00;
                  end
               end else begin
                  next_cur.sync_strobe = 1'b0;
                  next_cur.count = GAP_CYC;
                  next_cur.state = gaps_pkg::GAPS_GAP;
               end
            end
         end

         gaps_pkg::GAPS_GAP: begin
            next_cur.count = cnt_m1;
            if (cur.count == 12'h001) begin
               next_cur.wa_done = 1'b1;
               next_cur.count = DONE_CYC;
               next_cur.state = gaps_pkg::GAPS_WADONE;
            end
         end

         gaps_pkg::GAPS_WADONE: begin
            next_cur.count = cnt_m1;
            if (cur.count == 12'h001) begin
               next_cur.wa_done = 1'b0;
               next_cur.fc = 1'b1;
               next_cur.count = FC_CYC;
               next_cur.state = gaps_pkg::GAPS_FCOMP;
               if (!cur.ctrl[`GAPS_CTRL_LATE_BIT]) begin
                  next_cur.data = 8'h00;
               end
            end
         end

         gaps_pkg::GAPS_FDLY: begin
            next_cur.count = cnt_m1;
            if (cur.count == 12'h001) begin
               next_cur.fdly = 1'b0;
               next_cur.sync_strobe = 1'b0;
               next_cur.execute_pulse_strobe = 1'b1;
               next_cur.execute_pulse_pulse = 1'b1;
               next_cur.restart = 1'b1;
               next_cur.count = EXECUTE_PULSE_CYC;
               next_cur.state = gaps_pkg::GAPS_EXECUTE_PULSE;
            end
         end

         gaps_pkg::GAPS_EXECUTE_PULSE: begin
            next_cur.count = cnt_m1;
            if (cur.count == 12'h001) begin
               next_cur.execute_pulse_strobe = 1'b0;
               next_cur.write_req = 1'b1;
               // Dark moves skip the unblank phase entirely
               if (cur.mode == gaps_pkg::GAPS_VECTOR && cur.dark) begin
                  next_cur.dark = 1'b0;
                  next_cur.unblank_done = 1'b1;
                  next_cur.count = DONE_CYC;
                  next_cur.state = gaps_pkg::GAPS_UDONE;
               end else begin
                  next_cur.unblank = 1'b1;
                  next_cur.count = UNBL_CYC;
                  next_cur.state = gaps_pkg::GAPS_UNBL;
               end
            end
         end

         gaps_pkg::GAPS_UNBL: begin
            next_cur.count = cnt_m1;
            if (cur.count == 12'h001) begin
               next_cur.unblank = 1'b0;
               next_cur.unblank_done = 1'b1;
               next_cur.count = DONE_CYC;
               next_cur.state = gaps_pkg::GAPS_UDONE;
            end
         end

         gaps_pkg::GAPS_UDONE: begin
            next_cur.count = cnt_m1;
            if (cur.count == 12'h001) begin
               next_cur.unblank_done = 1'b0;
               next_cur.fc = 1'b1;
               next_cur.count = FC_CYC;
               next_cur.state = gaps_pkg::GAPS_FCOMP;
               if (!cur.ctrl[`GAPS_CTRL_LATE_BIT]) begin
                  next_cur.data = 8'h00;
               end
            end
         end

         gaps_pkg::GAPS_FCOMP: begin
            next_cur.count = cnt_m1;
            if (cur.count == 12'h001) begin
               next_cur.fc = 1'b0;
               next_cur.data = 8'h00;
               next_cur.receive_ready = 1'b1;
               next_cur.wa_n = 1'b0;
               if (cur.enter_plot) begin
                  // Both assembly flags up: switch into graphics
                  next_cur.mode = cur.pend_mode;
                  next_cur.graphics = 1'b1;
                  next_cur.text_flag = 1'b0;
                  next_cur.text2 = 1'b0;
                  next_cur.last_was_ylo = 1'b0;
               end else if (cur.leave_text) begin
                  next_cur.mode = gaps_pkg::GAPS_TEXT;
                  next_cur.graphics = 1'b0;
                  next_cur.text_flag = 1'b1;
                  next_cur.text2 = 1'b1;
                  next_cur.wa = 1'b0;
                  next_cur.wa_partner = 1'b0;
                  next_cur.dark = 1'b0;
               end else if (cur.ctl_char) begin
                  next_cur.text_flag = 1'b0;
               end
               next_cur.state = gaps_pkg::GAPS_IDLE;
            end
         end

         default: begin
            next_cur.state = gaps_pkg::GAPS_IDLE;
            next_cur.receive_ready = 1'b1;
         end
      endcase
   end

   // State register; outside idle the count steps down each pclk and reloads as each timed state but FCOMP ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
         cur.ctrl <= 5'(`GAPS_CTRL_RESET);
         cur.receive_ready <= 1'b1;
         cur.text_flag <= 1'b1;
         cur.text2 <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs straight from the state flops
   assign prdata = cur.prdata;
   assign pready = cur.pready;
   assign pslverr = cur.pslverr;
   assign receive_ready = cur.receive_ready;
   assign latched_data_lines = cur.data;
   assign sync_strobe = cur.sync_strobe;
   assign y_high_load = cur.loads[3];
   assign x_high_load = cur.loads[2];
   assign y_low_load = cur.loads[1];
   assign x_low_load = cur.loads[0];
   assign x_position = cur.x;
   assign y_position = cur.y;
   assign graph_command_seen = cur.gcs;
   assign word_assembly_flag = cur.wa;
   assign word_assembly_partner = cur.wa_partner;
   assign word_assembly_flag_n = cur.wa_n;
   assign word_assembly_done = cur.wa_done;
   assign function_complete = cur.fc;
   assign final_byte_delay = cur.fdly;
   assign execute_strobe = cur.execute_pulse_strobe;
   assign execute_pulse = cur.execute_pulse_pulse;
   assign display_timer_restart = cur.restart;
   assign point_write_request = cur.write_req;
   assign beam_unblank = cur.unblank;
   assign unblank_done = cur.unblank_done;
   assign text_flag = cur.text_flag;
   // Second text flag has its own flop, kept opposite to graphics
   assign text_flag_second = cur.text2;
   assign graphics_mode_flag = cur.graphics;
   assign dark_vector = cur.dark;

endmodule

`default_nettype wire

//--- dv/gaps_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host side of the receive handshake: one character per ready
module gaps_host (
   input wire logic pclk,
   input wire logic receive_ready,
   output logic receive_strobe,
   output logic [7:0] rx_data
);
   // Idle lines at time zero
   initial begin
      receive_strobe = 1'b0;
      rx_data = 8'h00;
   end

   // Offer a character, hold it until taken, then wait for ready again
   task automatic send(input logic [7:0] c);
      receive_strobe <= 1'b1;
      rx_data <= c;
      do @(posedge pclk); while (receive_ready !== 1'b1);
      receive_strobe <= 1'b0;
      // Released data must not look like the old value
      rx_data <= ~c;
      do @(posedge pclk); while (receive_ready !== 1'b1);
   endtask
endmodule
`default_nettype wire

//--- dv/gaps_sequencer_sva.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the receive handshake and the pulse chain at the top ports
module gaps_sequencer_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic receive_strobe,
   input wire logic receive_ready,
   input wire logic [7:0] latched_data_lines,
   input wire logic sync_strobe,
   input wire logic y_high_load,
   input wire logic y_low_load,
   input wire logic x_high_load,
   input wire logic x_low_load,
   input wire logic word_assembly_done,
   input wire logic function_complete,
   input wire logic final_byte_delay,
   input wire logic execute_strobe,
   input wire logic execute_pulse,
   input wire logic display_timer_restart,
   input wire logic point_write_request,
   input wire logic beam_unblank,
   input wire logic unblank_done,
   input wire logic text_flag,
   input wire logic graph_command_seen,
   input wire logic word_assembly_flag,
   input wire logic word_assembly_partner,
   input wire logic word_assembly_flag_n,
   input wire logic text_flag_second,
   input wire logic graphics_mode_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_one_load: assert property ($onehot0({y_high_load, y_low_load,
      x_high_load, x_low_load})) else $error("two loads at once");
   a_load_sync: assert property ((y_high_load || y_low_load ||
      x_high_load || x_low_load) |-> sync_strobe) else $error("load no sync");
   a_ready_drop: assert property (receive_strobe && receive_ready
      |=> !receive_ready) else $error("ready stayed high");
   a_gap_done: assert property ($fell(y_high_load) |-> ##10
      $rose(word_assembly_done)) else $error("done pulse late");
   a_done_comp: assert property ($rose(word_assembly_done) |-> ##20
      $rose(function_complete)) else $error("complete late");
   a_fdly_sync: assert property (final_byte_delay |-> sync_strobe)
      else $error("sync ended early");
   a_execute_pulse_start: assert property ($fell(final_byte_delay) |->
      execute_strobe && execute_pulse && display_timer_restart
      && !sync_strobe) else $error("execute not started");
   a_execute_pulse_end: assert property ($fell(final_byte_delay) |-> ##10
      ($fell(execute_strobe) && point_write_request))
      else $error("execute width wrong");
   a_unblank_len: assert property ($rose(beam_unblank) |-> ##40
      ($fell(beam_unblank) && unblank_done)) else $error("unblank width");
   a_fc_ready: assert property ($fell(function_complete)
      |-> receive_ready) else $error("ready not restored");
   a_fc_clear: assert property ($fell(function_complete) |->
      latched_data_lines == 8'h00) else $error("latches not cleared");
   a_gcs_flags: assert property (graph_command_seen |->
      word_assembly_flag && word_assembly_partner)
      else $error("assembly flags low");
   a_ctl_text: assert property (word_assembly_flag_n |-> text_flag)
      else $error("text flag low in control");
   a_flag_compl: assert property (text_flag_second
      == !graphics_mode_flag) else $error("text flag not complement");

   c_point: cover property ($rose(beam_unblank));
   c_byte: cover property ($rose(word_assembly_done));
   c_graph: cover property ($rose(graphics_mode_flag));
endmodule

bind gaps_sequencer gaps_sequencer_sva gaps_sequencer_sva_i (.pclk,
   .presetn, .receive_strobe, .receive_ready, .latched_data_lines,
   .sync_strobe, .y_high_load, .y_low_load, .x_high_load, .x_low_load,
   .word_assembly_done, .function_complete, .final_byte_delay,
   .execute_strobe, .execute_pulse, .display_timer_restart,
   .point_write_request, .beam_unblank, .unblank_done, .text_flag,
   .graph_command_seen, .word_assembly_flag, .word_assembly_partner,
   .word_assembly_flag_n, .text_flag_second, .graphics_mode_flag);
`default_nettype wire

//--- dv/tb_graphic_address_plot_sequencer.sv
`timescale 1ns/1ps
`include "gaps_map.svh"
`default_nettype none

module tb_graphic_address_plot_sequencer;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic receive_strobe, receive_ready, sync_strobe, unb_q;
   logic [7:0] rx_data, latched_data_lines;
   logic [9:0] x_position, y_position;
   logic y_high_load, y_low_load, x_high_load, x_low_load;
   logic graph_command_seen, word_assembly_flag, word_assembly_partner;
   logic word_assembly_flag_n, word_assembly_done, function_complete;
   logic final_byte_delay, execute_strobe, execute_pulse;
   logic display_timer_restart, point_write_request, beam_unblank;
   logic unblank_done, text_flag, text_flag_second, graphics_mode_flag;
   logic dark_vector;
   int errors, compares, flashes;

   gaps_sequencer gaps_sequencer_i (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .receive_strobe, .rx_data, .receive_ready, .latched_data_lines,
      .sync_strobe, .y_high_load, .y_low_load, .x_high_load, .x_low_load,
      .x_position, .y_position, .graph_command_seen, .word_assembly_flag,
      .word_assembly_partner, .word_assembly_flag_n, .word_assembly_done,
      .function_complete, .final_byte_delay, .execute_strobe,
      .execute_pulse, .display_timer_restart, .point_write_request,
      .beam_unblank, .unblank_done, .text_flag, .text_flag_second,
      .graphics_mode_flag, .dark_vector);

   gaps_host gaps_host_i (.pclk, .receive_ready, .receive_strobe, .rx_data);

   // 20 MHz clock
   initial pclk = 1'b0;
   always #25 pclk = ~pclk;

   // Count unblank pulses; a dark move leaves the count alone
   always @(posedge pclk) begin
      unb_q <= beam_unblank;
      if (beam_unblank === 1'b1 && unb_q === 1'b0)
         flashes++;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; read data lands in rd, error flag is compared
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      check({31'h0, pslverr}, {31'h0, err});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Four-byte address in the default high Y, low Y, high X, low X order
   task automatic addr(input logic [9:0] x, input logic [9:0] y);
      gaps_host_i.send({3'b011, y[9:5]});
      gaps_host_i.send({3'b110, y[4:0]});
      gaps_host_i.send({3'b010, x[9:5]});
      gaps_host_i.send({3'b101, x[4:0]});
      check({22'h0, y_position}, {22'h0, y});
      check({22'h0, x_position}, {22'h0, x});
      check({24'h0, latched_data_lines}, 32'h0);
   endtask

   task automatic mode(input logic [31:0] exp);
      apb(1'b0, `GAPS_STATUS_ADDR, 32'h0, 1'b0);
      check(rd & 32'h0000000c, exp);
   endtask

   task automatic summarize();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      unb_q = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({28'h0, receive_ready, text_flag, text_flag_second,
         graphics_mode_flag}, 32'he);
      apb(1'b0, `GAPS_CTRL_ADDR, 32'h0, 1'b0);
      check(rd, 32'h04);
      apb(1'b1, `GAPS_CTRL_ADDR, 32'h14, 1'b0);
      apb(1'b0, `GAPS_CTRL_ADDR, 32'h0, 1'b0);
      check(rd, 32'h14);
      apb(1'b0, 12'hffc, 32'h0, 1'b1);
      check(rd, 32'h0);
      gaps_host_i.send(`GAPS_CHR_FS);
      check({30'h0, text_flag, graphics_mode_flag}, 32'h1);
      check({30'h0, word_assembly_flag, word_assembly_partner}, 32'h3);
      addr(10'h13c, 10'h2a5);
      check(32'(flashes), 32'h1);
      gaps_host_i.send(`GAPS_CHR_RS);
      gaps_host_i.send(`GAPS_CHR_FS);
      mode(32'h04);
      gaps_host_i.send(`GAPS_CHR_US);
      check({30'h0, text_flag, graphics_mode_flag}, 32'h2);
      check({30'h0, word_assembly_flag, word_assembly_partner}, 32'h0);
      gaps_host_i.send(`GAPS_CHR_GS);
      mode(32'h08);
      check({31'h0, dark_vector}, 32'h1);
      addr(10'h3ff, 10'h000);
      check(32'(flashes), 32'h1);
      check({31'h0, dark_vector}, 32'h0);
      addr(10'h001, 10'h3e0);
      check(32'(flashes), 32'h2);
      gaps_host_i.send(`GAPS_CHR_GS);
      check({31'h0, dark_vector}, 32'h1);
      addr(10'h155, 10'h2aa);
      check(32'(flashes), 32'h2);
      // Low X, high Y, low Y, high X order; high X ends the address
      apb(1'b1, `GAPS_CTRL_ADDR, 32'h16, 1'b0);
      gaps_host_i.send(8'h91);
      gaps_host_i.send(8'h55);
      gaps_host_i.send(8'hc3);
      gaps_host_i.send(8'h4a);
      check({22'h0, x_position}, 32'h151);
      check({22'h0, y_position}, 32'h2a3);
      check(32'(flashes), 32'h3);
      // CR returns to text only with its option strapped
      apb(1'b1, `GAPS_CTRL_ADDR, 32'h1c, 1'b0);
      gaps_host_i.send(`GAPS_CHR_CR);
      mode(32'h00);
      gaps_host_i.send(`GAPS_CHR_US);
      mode(32'h00);
      summarize();
   end

   // Whole run needs about 22000 cycles
   initial begin
      repeat (60000) @(posedge pclk);
      errors++;
      summarize();
   end
endmodule
`default_nettype wire
